// ==== bench/smc_dbg_host.sv ====
// Serial debug host model driving the debug command pins.
// Assumes a one-cycle response pulse on the controller clock.
`default_nettype none
module smc_dbg_host (
    // Clock
    input  wire logic       clk,
    // Command pins
    output var  logic       strobe,
    output var  logic [7:0] code,
    output var  logic [7:0] data,
    // Response
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        strobe = 1'h0;
        code = 8'h00;
        data = 8'h00;
    end
    // Debug register reached only by serial commands
    task automatic send(input logic [7:0] c, input logic [7:0] d, output logic [7:0] r);
        code <= c;
        data <= d;
        @(posedge clk) strobe <= 1'h1;
        do @(posedge clk); while (rsp_valid !== 1'h1);
        r = rsp_data;
        strobe <= 1'h0;
        repeat (4) @(posedge clk);
        // Hold over: stale command words are never left looking valid
        code <= ~c;
        data <= ~d;
        @(posedge clk);
    endtask
endmodule // smc_dbg_host
`default_nettype wire

// ==== bench/smc_sva.sv ====
// Checker for the stop mode controller, bound to smc_top.
// Assumes one clock domain with synchronous active-high reset.
`default_nettype none
module smc_sva (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Activity inputs
    input wire logic WAKE_EVENT,
    input wire logic SENSOR_BUSY,
    input wire logic RADIO_TX_BUSY,
    input wire logic RADIO_SEND,
    input wire logic RADIO_DIRECT,
    // Watched controls
    input wire logic PERIPH_CLK_EN,
    input wire logic WAKEUP_CLK_EN,
    input wire logic REGULATOR_FULL,
    input wire logic HFO_EN,
    input wire logic MFO_EN,
    input wire logic RADIO_PWR_EN,
    input wire logic TIMER_CLK_EN,
    input wire logic WATCHDOG_EN,
    input wire logic PIN_HIZ,
    input wire logic PIN_HOLD,
    input wire logic MODULE_RESET,
    input wire logic RESET_VECTOR_FETCH,
    input wire logic ILLEGAL_RESET,
    input wire logic TICK_FLAG
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // Either stop mode, seen through the pin controls
    wire logic stop_now = PIN_HIZ | PIN_HOLD;
    sequence deep_wake_s;
        PIN_HIZ && WAKE_EVENT;
    endsequence
    sequence reset_pulse_s;
        MODULE_RESET && RESET_VECTOR_FETCH;
    endsequence
    periph_gate_a: assert property (stop_now |-> !PERIPH_CLK_EN && WAKEUP_CLK_EN)
        else $error("Peripheral clocks running in stop");
    deep_hiz_a: assert property (PIN_HIZ |-> !PIN_HOLD && !REGULATOR_FULL)
        else $error("Deep stop pins or regulator wrong");
    hfo_halt_a: assert property (PIN_HIZ |-> !HFO_EN)
        else $error("High oscillator running in deep stop");
    wdog_timer_a: assert property (stop_now |-> !WATCHDOG_EN && !TIMER_CLK_EN)
        else $error("Watchdog or timer running in stop");
    wake_seq_a: assert property (deep_wake_s |-> ##[1:2] reset_pulse_s)
        else $error("Deep wake without module reset");
    wake_end_a: assert property (MODULE_RESET |=> !MODULE_RESET ##1 !PIN_HIZ)
        else $error("Module reset not a single pulse");
    mfo_idle_a: assert property ((stop_now && !SENSOR_BUSY && !RADIO_TX_BUSY) [*2] |-> !MFO_EN)
        else $error("Medium oscillator on while idle in stop");
    radio_keep_a: assert property ((stop_now && (RADIO_TX_BUSY || (RADIO_SEND && RADIO_DIRECT))) [*2]
        |-> RADIO_PWR_EN) else $error("Radio chain unpowered while sending");
    tick_mask_a: assert property (PIN_HIZ [*2] |-> !$rose(TICK_FLAG))
        else $error("Tick flag set in deep stop");
    illegal_stop_a: assert property (ILLEGAL_RESET |-> !stop_now ##1 !ILLEGAL_RESET)
        else $error("Illegal stop entered stop or held reset");
endmodule // smc_sva
bind smc_top smc_sva chk (.SYS_CLK, .RST, .WAKE_EVENT, .SENSOR_BUSY, .RADIO_TX_BUSY, .RADIO_SEND,
    .RADIO_DIRECT, .PERIPH_CLK_EN, .WAKEUP_CLK_EN, .REGULATOR_FULL, .HFO_EN, .MFO_EN, .RADIO_PWR_EN,
    .TIMER_CLK_EN, .WATCHDOG_EN, .PIN_HIZ, .PIN_HOLD, .MODULE_RESET, .RESET_VECTOR_FETCH,
    .ILLEGAL_RESET, .TICK_FLAG);
`default_nettype wire

// ==== bench/tb_stop_mode_controller.sv ====
// Self-checking bench for the stop mode controller.
// Assumes zero-wait APB on smc_top and the serial debug host model.
`include "smc_defines.svh"
`default_nettype none
module tb_stop_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    logic        SYS_CLK = 1'h0;
    logic        RST = 1'h1;
    logic        PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, STOP_EXEC = 1'h0, WAKE_EVENT = 1'h0;
    logic        SENSOR_BUSY = 1'h0, RADIO_TX_BUSY = 1'h0, RADIO_SEND = 1'h0, RADIO_DIRECT = 1'h0;
    logic        LFR_SAMPLE = 1'h0, TICK_EVENT = 1'h0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA, rd, first;
    logic        err;
    logic [7:0]  DBG_CODE, DBG_DATA, DBG_RSP_DATA, rsp;
    logic [2:0]  seen;
    logic        PREADY, PSLVERR, DBG_STROBE, DBG_RSP_VALID, PERIPH_CLK_EN, DEBUG_CLK_EN, WAKEUP_CLK_EN;
    logic        REGULATOR_FULL, HFO_EN, MFO_EN, RADIO_PWR_EN, LFR_DET_EN, ADC_RUN_EN, TIMER_CLK_EN;
    logic        WATCHDOG_EN, PIN_HIZ, PIN_HOLD, MEM_STANDBY, MODULE_RESET, ILLEGAL_RESET;
    logic        RESET_VECTOR_FETCH, TICK_FLAG, DEBUG_ACTIVE;
    int          bad_count = 0, checked = 0;
    wire logic [8:0] ctl = {ADC_RUN_EN, PERIPH_CLK_EN, WAKEUP_CLK_EN, REGULATOR_FULL, HFO_EN,
                            PIN_HIZ, PIN_HOLD, TIMER_CLK_EN, WATCHDOG_EN};
    smc_top dut (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .STOP_EXEC, .WAKE_EVENT, .SENSOR_BUSY, .RADIO_TX_BUSY, .RADIO_SEND, .RADIO_DIRECT, .LFR_SAMPLE,
        .TICK_EVENT, .DBG_STROBE, .DBG_CODE, .DBG_DATA, .DBG_RSP_VALID, .DBG_RSP_DATA, .PERIPH_CLK_EN,
        .DEBUG_CLK_EN, .WAKEUP_CLK_EN, .REGULATOR_FULL, .HFO_EN, .MFO_EN, .RADIO_PWR_EN, .LFR_DET_EN,
        .ADC_RUN_EN, .TIMER_CLK_EN, .WATCHDOG_EN, .PIN_HIZ, .PIN_HOLD, .MEM_STANDBY, .MODULE_RESET,
        .ILLEGAL_RESET, .RESET_VECTOR_FETCH, .TICK_FLAG, .DEBUG_ACTIVE);
    smc_dbg_host host (.clk(SYS_CLK), .strobe(DBG_STROBE), .code(DBG_CODE), .data(DBG_DATA),
        .rsp_valid(DBG_RSP_VALID), .rsp_data(DBG_RSP_DATA));
    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK) PENABLE <= 1'h1;
        do @(posedge SYS_CLK); while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge SYS_CLK);
    endtask
    task automatic rst_dut;
        RST <= 1'h1;
        cyc(10);
        RST <= 1'h0;
        cyc(1);
    endtask
    // Pulses stop or wake, then gathers the reset pulses that follow
    task automatic go(input logic stp);
        STOP_EXEC <= stp;
        WAKE_EVENT <= ~stp;
        cyc(1);
        STOP_EXEC <= 1'h0;
        WAKE_EVENT <= 1'h0;
        seen = 3'h0;
        repeat (4) begin
            @(posedge SYS_CLK);
            seen = seen | {ILLEGAL_RESET, MODULE_RESET, RESET_VECTOR_FETCH};
        end
    endtask
    // Eleven tick pulses, longer than one divider period
    task automatic ticks;
        repeat (2 * (`SMC_TICK_DIV + 2)) begin
            TICK_EVENT <= ~TICK_EVENT;
            cyc(1);
        end
    endtask
    task automatic t_reset;
        chk(32'(ctl), 32'h0000_01F3);
        apb(1'h0, 12'h080, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(32'(err), 32'h0000_0000);
        go(1'h1);
        chk(32'({seen, ctl}), 32'h0000_09F3);
    endtask
    task automatic t_deep;
        apb(1'h1, `SMC_OFF_CTRL, 32'h0000_0027);
        go(1'h1);
        chk(32'(ctl), 32'h0000_0048);
        RADIO_SEND <= 1'h1;
        RADIO_DIRECT <= 1'h1;
        ticks;
        chk(32'({MFO_EN, RADIO_PWR_EN, TICK_FLAG}), 32'h0000_0002);
        apb(1'h0, `SMC_OFF_FRC, 32'h0000_0000);
        first = rd;
        apb(1'h0, `SMC_OFF_FRC, 32'h0000_0000);
        chk(rd - first, 32'h0000_0003);
        SENSOR_BUSY <= 1'h1;
        cyc(3);
        chk(32'(MFO_EN), 32'h0000_0001);
        SENSOR_BUSY <= 1'h0;
        RADIO_DIRECT <= 1'h0;
        RADIO_TX_BUSY <= 1'h1;
        cyc(2);
        chk(32'({MFO_EN, RADIO_PWR_EN}), 32'h0000_0003);
        RADIO_TX_BUSY <= 1'h0;
        cyc(3);
        chk(32'({MFO_EN, RADIO_PWR_EN}), 32'h0000_0001);
        RADIO_SEND <= 1'h0;
        go(1'h0);
        chk(32'({seen, ctl}), 32'h0000_07F3);
        apb(1'h0, `SMC_OFF_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask
    task automatic t_param;
        apb(1'h1, 12'h104, 32'h0000_00A5);
        rst_dut;
        apb(1'h0, 12'h104, 32'h0000_0000);
        chk(rd & 32'h0000_00FF, 32'h0000_00A5);
    endtask
    task automatic t_light;
        apb(1'h1, `SMC_OFF_PWR, 32'h0000_0003);
        apb(1'h1, `SMC_OFF_CTRL, 32'h0000_0033);
        LFR_SAMPLE <= 1'h1;
        go(1'h1);
        chk(32'(ctl), 32'h0000_0164);
        ticks;
        chk(32'({MEM_STANDBY, LFR_DET_EN, TICK_FLAG}), 32'h0000_0007);
        apb(1'h0, `SMC_OFF_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        apb(1'h1, `SMC_OFF_STATUS, 32'h0000_0001);
        apb(1'h0, `SMC_OFF_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        LFR_SAMPLE <= 1'h0;
        rst_dut;
    endtask
    task automatic t_debug;
        host.send(`SMC_DBG_WRITE_CONTROL, 8'(1 << `SMC_DBG_ENABLE_BIT), rsp);
        host.send(`SMC_DBG_READ_STATUS, 8'h00, rsp);
        chk(32'(rsp[`SMC_DBG_ENABLE_BIT]), 32'h0000_0001);
        apb(1'h1, `SMC_OFF_CTRL, 32'h0000_0003);
        go(1'h1);
        chk(32'({DEBUG_CLK_EN, ctl}), 32'h0000_0374);
        host.send(`SMC_DBG_MEM_STATUS, 8'h00, rsp);
        chk(32'(rsp), 32'(`SMC_DBG_ERR_STOP));
        host.send(`SMC_DBG_HALT, 8'h00, rsp);
        cyc(2);
        chk(32'(DEBUG_ACTIVE), 32'h0000_0001);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst_dut;
        t_reset;
        t_deep;
        t_param;
        t_light;
        t_debug;
        print_verdict;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        cyc(5000);
        bad_count++;
        print_verdict;
    end
endmodule // tb_stop_mode_controller
`default_nettype wire

// ==== hdl/smc_dbg_if.sv ====
// Interface carrying debug commands from the serial front end to the controller.
// Assumes one clock domain shared by both ends.
`default_nettype none
interface smc_dbg_if;
    logic       cmd_valid;
    logic [7:0] cmd_code;
    logic [7:0] cmd_data;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    modport ctrl (input cmd_valid, input cmd_code, input cmd_data, output rsp_valid, output rsp_data);
    modport port (output cmd_valid, output cmd_code, output cmd_data, input rsp_valid, input rsp_data);
endinterface
`default_nettype wire

// ==== hdl/smc_dbg_port.sv ====
// Debug command front end: synchronises the command strobe and holds command words.
// Assumes command pins are asynchronous and held stable around the strobe.
`include "smc_defines.svh"
`default_nettype none
module smc_dbg_port (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Raw pins
    input  wire logic       strobe_pin,
    input  wire logic [7:0] code_pin,
    input  wire logic [7:0] data_pin,
    // Toward controller
    smc_dbg_if.port         dbg
);
    logic [2:0] sync;
    logic       seen;

    // Three stages; a change counts once the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            sync <= 3'h0;
        end else begin
            sync <= {sync[1:0], strobe_pin};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            seen          <= 1'b0;
            dbg.cmd_valid <= 1'b0;
            dbg.cmd_code  <= 8'h00;
            dbg.cmd_data  <= 8'h00;
        end else begin
            dbg.cmd_valid <= 1'b0;
            if (sync[1] == sync[2]) begin
                seen <= sync[2];
                if (sync[2] && !seen) begin
                    dbg.cmd_valid <= 1'b1;
                    dbg.cmd_code  <= code_pin;
                    dbg.cmd_data  <= data_pin;
                end
            end
        end
    end
endmodule // smc_dbg_port
`default_nettype wire

// ==== hdl/smc_defines.svh ====
// Constants for the stop mode controller: register offsets, field bits, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
`define SMC_OFF_CTRL      12'h000
`define SMC_OFF_PWR       12'h004
`define SMC_OFF_STATUS    12'h008
`define SMC_OFF_FRC       12'h00C
`define SMC_OFF_PARAM     12'h100
`define SMC_PARAM_BYTES   64
`define SMC_PARAM_PAGE    4'h1
`define SMC_CTRL_RESET    32'h0000_0000
`define SMC_PWR_RESET     32'h0000_0000
`define SMC_B_STOP_INSTRUCTION_ENABLE       0
`define SMC_B_DEEP_SEL    1
`define SMC_B_FRC_EN      2
`define SMC_B_FRC_HALT    3
`define SMC_B_LFR_EN      4
`define SMC_B_TICK_EN     5
`define SMC_B_LOW_VOLTAGE_DETECT_ENABLE        0
`define SMC_B_LOW_VOLTAGE_DETECT_IN_STOP_ENABLE       1
`define SMC_DBG_READ_STATUS   8'hE4
`define SMC_DBG_WRITE_CONTROL 8'hC4
`define SMC_DBG_HALT          8'h90
`define SMC_DBG_MEM_STATUS    8'hE1
`define SMC_DBG_ERR_STOP      8'hFF
`define SMC_DBG_ENABLE_BIT    7
`define SMC_TICK_DIV      16'h0009
`endif

// ==== hdl/smc_pkg.sv ====
// Types for the stop mode controller.
// Assumes smc_defines.svh is available for the numeric constants.
`default_nettype none
package smc_pkg;
    typedef enum logic [2:0] {SMC_RUN, SMC_LIGHT, SMC_DEEP, SMC_WAKE, SMC_DEBUG} smc_mode_t;
endpackage
`default_nettype wire

// ==== hdl/smc_top.sv ====
// Stop mode controller: picks deep or light stop, gates clocks and power, handles debug in stop.
// Assumes APB master on SYS_CLK and that peripherals obey the enables driven here.
//
// Local design decisions: register access over APB and the placing of the registers.
`include "smc_defines.svh"
`default_nettype none
// Operation
// - Regulator stays on with stop-mode voltage detect
// - Stop-mode voltage detect turns deep into light
// - Debug enable keeps debug clock and regulator
// - Debug enable turns deep into clocked light
// - Debug status register only via debug commands
// - Memory status commands in stop return error
// - Halt command in stop wakes into debug
// - Stop gates peripheral clocks except wakeup, receiver
// - Deep stop forces pins high impedance
// - Deep wake resets modules and loses RAM
// - Parameter registers survive every reset
// - Enabled counter counts in every mode
// - Medium oscillator on for measurement or transmit
// - High oscillator halted in stop, except light stop with debug enabled
// - Converter runs in light, resets after deep
// - Timer halts in stop, resets after deep
// - Tick flag suppressed in deep stop only
// - Receiver detectors follow sampling bits in stop
// - Radio chain powered transmitting or send direct
// - Radio chain stays on after transmitting while send set
// - Watchdog stopped in both stops
// - Disabled stop instruction forces illegal reset
// - Deep wake restarts through reset vector
module smc_top (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Processor events
    input  wire logic        STOP_EXEC,
    input  wire logic        WAKE_EVENT,
    // Peripheral activity inputs
    input  wire logic        SENSOR_BUSY,
    input  wire logic        RADIO_TX_BUSY,
    input  wire logic        RADIO_SEND,
    input  wire logic        RADIO_DIRECT,
    input  wire logic        LFR_SAMPLE,
    input  wire logic        TICK_EVENT,
    // Debug pins
    input  wire logic        DBG_STROBE,
    input  wire logic [7:0]  DBG_CODE,
    input  wire logic [7:0]  DBG_DATA,
    output logic             DBG_RSP_VALID,
    output logic      [7:0]  DBG_RSP_DATA,
    // Clock and power controls
    output logic             PERIPH_CLK_EN,
    output logic             DEBUG_CLK_EN,
    output logic             WAKEUP_CLK_EN,
    output logic             REGULATOR_FULL,
    output logic             HFO_EN,
    output logic             MFO_EN,
    output logic             RADIO_PWR_EN,
    output logic             LFR_DET_EN,
    output logic             ADC_RUN_EN,
    output logic             TIMER_CLK_EN,
    output logic             WATCHDOG_EN,
    // Pin and reset controls
    output logic             PIN_HIZ,
    output logic             PIN_HOLD,
    output logic             MEM_STANDBY,
    output logic             MODULE_RESET,
    output logic             ILLEGAL_RESET,
    output logic             RESET_VECTOR_FETCH,
    output logic             TICK_FLAG,
    output logic             DEBUG_ACTIVE
);
    smc_dbg_if dbg ();

    smc_dbg_port u_port (
        .clk        (SYS_CLK),
        .rst        (RST),
        .strobe_pin (DBG_STROBE),
        .code_pin   (DBG_CODE),
        .data_pin   (DBG_DATA),
        .dbg        (dbg.port)
    );

    smc_pkg::smc_mode_t mode;
    smc_pkg::smc_mode_t next_mode;
    logic [31:0] ctrl;
    logic [31:0] pwr;
    logic [7:0]  debug_status_control;
    logic [31:0] free_running_counter;
    logic [15:0] tick_div;
    logic        radio_hold;
    logic [7:0]  param [0:`SMC_PARAM_BYTES-1];
    logic        apb_wr;
    logic [5:0]  param_idx;

    function automatic logic in_stop(input smc_pkg::smc_mode_t m);
        in_stop = (m == smc_pkg::SMC_LIGHT) || (m == smc_pkg::SMC_DEEP);
    endfunction

    // Parameter page decode shared by the read and write paths
    function automatic logic param_hit(input logic [11:0] a);
        param_hit = a[11:8] == `SMC_PARAM_PAGE;
    endfunction

    wire dbg_en  = debug_status_control[`SMC_DBG_ENABLE_BIT];
    wire lvd_hold = pwr[`SMC_B_LOW_VOLTAGE_DETECT_ENABLE] && pwr[`SMC_B_LOW_VOLTAGE_DETECT_IN_STOP_ENABLE];
    wire stop_ok  = ctrl[`SMC_B_STOP_INSTRUCTION_ENABLE];
    // Light stop is the fallback whenever deep stop is barred
    wire deep_ok  = ctrl[`SMC_B_DEEP_SEL] && !pwr[`SMC_B_LOW_VOLTAGE_DETECT_IN_STOP_ENABLE] && !dbg_en;
    wire dbg_halt = dbg.cmd_valid && dbg.cmd_code == `SMC_DBG_HALT;

    assign apb_wr    = PSEL && PENABLE && PWRITE;
    assign param_idx = PADDR[7:2];
    assign PREADY    = 1'b1;
    assign PSLVERR   = 1'b0;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            smc_pkg::SMC_RUN: begin
                if (STOP_EXEC && stop_ok) begin
                    next_mode = deep_ok ? smc_pkg::SMC_DEEP : smc_pkg::SMC_LIGHT;
                end
            end
            smc_pkg::SMC_LIGHT: begin
                if (dbg_halt && dbg_en) begin
                    next_mode = smc_pkg::SMC_DEBUG;
                end else if (WAKE_EVENT) begin
                    next_mode = smc_pkg::SMC_RUN;
                end
            end
            smc_pkg::SMC_DEEP: begin
                if (WAKE_EVENT) begin
                    next_mode = smc_pkg::SMC_WAKE;
                end
            end
            smc_pkg::SMC_WAKE:  next_mode = smc_pkg::SMC_RUN;
            smc_pkg::SMC_DEBUG: begin
                if (WAKE_EVENT) begin
                    next_mode = smc_pkg::SMC_RUN;
                end
            end
            default: next_mode = smc_pkg::SMC_RUN;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            mode <= smc_pkg::SMC_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // Disabled stop instruction never enters stop
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ILLEGAL_RESET <= 1'b0;
        end else begin
            ILLEGAL_RESET <= (mode == smc_pkg::SMC_RUN) && STOP_EXEC && !stop_ok;
        end
    end

    // Deep wake acts like power-on: modules reset, reset vector taken
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            MODULE_RESET       <= 1'b0;
            RESET_VECTOR_FETCH <= 1'b0;
        end else begin
            MODULE_RESET       <= (next_mode == smc_pkg::SMC_WAKE);
            RESET_VECTOR_FETCH <= (next_mode == smc_pkg::SMC_WAKE);
        end
    end

    // Software registers; cleared by reset and by deep wake
    always_ff @(posedge SYS_CLK) begin
        if (RST || mode == smc_pkg::SMC_WAKE) begin
            ctrl <= `SMC_CTRL_RESET;
            pwr  <= `SMC_PWR_RESET;
        end else if (apb_wr && PADDR == `SMC_OFF_CTRL) begin
            ctrl <= PWDATA;
        end else if (apb_wr && PADDR == `SMC_OFF_PWR) begin
            pwr <= PWDATA;
        end
    end

    // Parameter bytes have no reset term, so they keep contents across all resets
    always_ff @(posedge SYS_CLK) begin
        if (apb_wr && param_hit(PADDR)) begin
            param[param_idx] <= PWDATA[7:0];
        end
    end

    // Debug status register: no APB decode, only debug commands
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            debug_status_control <= 8'h00;
            dbg.rsp_valid        <= 1'b0;
            dbg.rsp_data         <= 8'h00;
        end else begin
            dbg.rsp_valid <= 1'b0;
            if (dbg.cmd_valid) begin
                dbg.rsp_valid <= 1'b1;
                dbg.rsp_data  <= 8'h00;
                if (dbg.cmd_code == `SMC_DBG_WRITE_CONTROL) begin
                    debug_status_control <= dbg.cmd_data;
                end else if (dbg.cmd_code == `SMC_DBG_READ_STATUS) begin
                    dbg.rsp_data <= debug_status_control;
                end else if (dbg.cmd_code == `SMC_DBG_MEM_STATUS) begin
                    dbg.rsp_data <= in_stop(mode) ? `SMC_DBG_ERR_STOP : param[dbg.cmd_data[5:0]];
                end
            end
        end
    end

    // Counter keeps running in any mode once enabled
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            free_running_counter <= 32'h0000_0000;
        end else if (ctrl[`SMC_B_FRC_EN] && !ctrl[`SMC_B_FRC_HALT]) begin
            free_running_counter <= free_running_counter + 32'h0000_0001;
        end
    end

    // Tick flag: set suppressed in deep stop; set wins over clear
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            TICK_FLAG <= 1'b0;
        end else if (TICK_EVENT && ctrl[`SMC_B_TICK_EN] && mode != smc_pkg::SMC_DEEP) begin
            TICK_FLAG <= 1'b1;
        end else if (apb_wr && PADDR == `SMC_OFF_STATUS && PWDATA[0]) begin
            TICK_FLAG <= 1'b0;
        end
    end

    // Radio hold: latched while transmitting, held as long as send stays set
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            radio_hold <= 1'b0;
        end else begin
            radio_hold <= RADIO_SEND && (RADIO_TX_BUSY || radio_hold);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            tick_div <= 16'h0000;
        end else begin
            tick_div <= (tick_div == `SMC_TICK_DIV) ? 16'h0000 : tick_div + 16'h0001;
        end
    end

    // Power and clock controls registered from next_mode
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PERIPH_CLK_EN  <= 1'b1;
            DEBUG_CLK_EN   <= 1'b1;
            WAKEUP_CLK_EN  <= 1'b1;
            REGULATOR_FULL <= 1'b1;
            HFO_EN         <= 1'b1;
            MFO_EN         <= 1'b0;
            RADIO_PWR_EN   <= 1'b0;
            LFR_DET_EN     <= 1'b0;
            ADC_RUN_EN     <= 1'b1;
            TIMER_CLK_EN   <= 1'b1;
            WATCHDOG_EN    <= 1'b1;
            PIN_HIZ        <= 1'b0;
            PIN_HOLD       <= 1'b0;
            MEM_STANDBY    <= 1'b0;
        end else begin
            PERIPH_CLK_EN  <= !in_stop(next_mode);
            DEBUG_CLK_EN   <= !in_stop(next_mode) || dbg_en;
            WAKEUP_CLK_EN  <= 1'b1;
            REGULATOR_FULL <= next_mode != smc_pkg::SMC_DEEP && (!in_stop(next_mode) || lvd_hold || dbg_en);
            HFO_EN         <= !in_stop(next_mode) || (next_mode == smc_pkg::SMC_LIGHT && dbg_en);
            MFO_EN         <= !in_stop(next_mode) || SENSOR_BUSY || RADIO_TX_BUSY;
            RADIO_PWR_EN   <= RADIO_TX_BUSY || (RADIO_SEND && RADIO_DIRECT) || radio_hold;
            LFR_DET_EN     <= ctrl[`SMC_B_LFR_EN] && (!in_stop(next_mode) || LFR_SAMPLE);
            ADC_RUN_EN     <= next_mode != smc_pkg::SMC_DEEP;
            TIMER_CLK_EN   <= !in_stop(next_mode);
            WATCHDOG_EN    <= !in_stop(next_mode);
            PIN_HIZ        <= next_mode == smc_pkg::SMC_DEEP;
            PIN_HOLD       <= next_mode == smc_pkg::SMC_LIGHT;
            MEM_STANDBY    <= next_mode == smc_pkg::SMC_LIGHT;
        end
    end

    // Debug mode is left only through a wake event
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DEBUG_ACTIVE <= 1'b0;
        end else begin
            DEBUG_ACTIVE <= next_mode == smc_pkg::SMC_DEBUG;
        end
    end

    // Combinational read data stands for the whole zero-wait access
    always_comb begin
        PRDATA = 32'h0000_0000;
        if (PSEL && !PWRITE) begin
            unique case (PADDR)
                `SMC_OFF_CTRL:   PRDATA = ctrl;
                `SMC_OFF_PWR:    PRDATA = pwr;
                `SMC_OFF_STATUS: PRDATA = {28'h000_0000, radio_hold, DEBUG_ACTIVE, in_stop(mode), TICK_FLAG};
                `SMC_OFF_FRC:    PRDATA = free_running_counter;
                default: begin
                    if (param_hit(PADDR)) begin
                        PRDATA = {24'h00_0000, param[param_idx]};
                    end
                end
            endcase
        end
    end

    assign DBG_RSP_VALID = dbg.rsp_valid;
    assign DBG_RSP_DATA  = dbg.rsp_data;
endmodule // smc_top
`default_nettype wire
